// ---- common/uad_pkg.sv ----
package uad_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_BAUD = 8'h0C;
   localparam logic [7:0] ADDR_IRQ = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   // serial_control_reg fields
   localparam int CTRL_RXBIT8 = 2;
   localparam int CTRL_TXBIT8 = 3;
   localparam int CTRL_RXEN = 4;
   localparam int CTRL_MODE_LO = 6;
   // serial_status_reg fields
   localparam int STAT_DBEN = 7;
   localparam int STAT_BAUDSEL = 6;
   localparam int STAT_TXBUSY = 1;
   localparam int STAT_HOLDFULL = 0;
   // irq bits
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] BAUD_RESET = 16'h0010;
   localparam logic [15:0] T1_RELOAD = 16'h0020;
   localparam logic [3:0] MODE0_DIV = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic [8:0] data;
   } uad_char_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_START = 4'h2,
      ST_BITS = 4'h4,
      ST_STOP = 4'h8
   } uad_state_t;
endpackage : uad_pkg

// ---- hw/uad_top.sv ----
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - 10-bit mode frame: low start, 8 data LSB first, high stop.
// - 10-bit mode receive stores stop bit into rx_ninth_bit.
// - 10-bit mode rate from timer 1 overflow or baud generator.
// - 11-bit mode frame: start, 8 data, ninth bit, stop.
// - 11-bit mode transmit sends tx_ninth_bit as ninth bit.
// - double_buffer_enable clear gives a single-buffered transmitter.
// - double buffering accepts a write while previous character shifts.
// - double buffering raises transmit interrupt when holding buffer frees.
// - single buffer uses tx_ninth_bit value present when shifted out.
// - double buffering captures tx_ninth_bit with data on write.
// - mode 0 shifts 8 bits via receive pin, transmit pin clocks.
module uad_top import uad_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rxdIn,
   output logic rxdOut,
   output logic rxdOe_b,
   output logic txdOut,
   input wire logic timer1Ovf,
   output logic irq
);
   logic [7:0] ctrl_q, stat_q;
   logic [15:0] baud_q, brgCnt_q;
   logic [1:0] irqSt_q, mask_q;
   logic awHave_q, wHave_q;
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic wrGo, dataWr;
   logic [1:0] mode;
   logic tick, rxTick;
   uad_char_t hold_q, txSh_q;
   logic holdFull_q;
   uad_state_t txSt_q, rxSt_q;
   logic [3:0] txBit_q, txPh_q, rxBit_q;
   logic [8:0] rxSh_q;
   logic [7:0] rxBuf_q;
   logic txDone, rxDone, txStartEv;
   logic t1Tog_q;

   assign mode = ctrl_q[CTRL_MODE_LO+1 -: 2];
   assign wrGo = awHave_q && wHave_q && !bvalid;
   assign dataWr = wrGo && awAddr_q == ADDR_DATA && wStrb_q[0];

   // write channel: address and data taken in either order
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         awready <= !awHave_q && !awready && awvalid;
         wready <= !wHave_q && !wready && wvalid;
         if (awready && awvalid) begin
            awHave_q <= 1'b1;
            awAddr_q <= awaddr;
         end
         if (wready && wvalid) begin
            wHave_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (wrGo) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            bvalid <= 1'b1;
            if (awAddr_q > ADDR_MASK || awAddr_q[1:0] != 2'h0) begin
               bresp <= RESP_SLVERR;
            end else begin
               bresp <= RESP_OKAY;
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // read channel
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         arready <= !arready && !rvalid && arvalid;
         if (arready && arvalid) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
            if (araddr == ADDR_CTRL) begin
               rdata[7:0] <= ctrl_q;
            end else if (araddr == ADDR_STAT) begin
               rdata[7:0] <= {stat_q[7:6], 4'h0, txSt_q != ST_IDLE, holdFull_q};
            end else if (araddr == ADDR_DATA) begin
               rdata[7:0] <= rxBuf_q;
            end else if (araddr == ADDR_BAUD) begin
               rdata[15:0] <= baud_q;
            end else if (araddr == ADDR_IRQ) begin
               rdata[1:0] <= irqSt_q;
            end else if (araddr == ADDR_MASK) begin
               rdata[1:0] <= mask_q;
            end else begin
               rresp <= RESP_SLVERR;
            end
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // software registers; rx_ninth_bit is hardware-owned
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= CTRL_RESET;
         stat_q <= 8'h00;
         baud_q <= BAUD_RESET;
         mask_q <= 2'h0;
      end else begin
         if (wrGo && wStrb_q[0]) begin
            if (awAddr_q == ADDR_CTRL) begin
               ctrl_q <= {wData_q[7:3], ctrl_q[CTRL_RXBIT8], wData_q[1:0]};
            end else if (awAddr_q == ADDR_STAT) begin
               stat_q <= {wData_q[7] && mode != 2'h0, wData_q[6], 6'h00};
            end else if (awAddr_q == ADDR_MASK) begin
               mask_q <= wData_q[1:0];
            end
         end
         if (wrGo && awAddr_q == ADDR_BAUD && wStrb_q[1:0] == 2'h3) begin
            baud_q <= wData_q[15:0];
         end
         if (rxDone) begin
            ctrl_q[CTRL_RXBIT8] <= rxSh_q[8];
         end
      end
   end

   // bit clock: timer 1 overflow or dedicated generator
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         brgCnt_q <= 16'h0000;
         t1Tog_q <= 1'b0;
      end else begin
         t1Tog_q <= timer1Ovf;
         if (brgCnt_q == 16'h0000) begin
            brgCnt_q <= stat_q[STAT_BAUDSEL] ? T1_RELOAD : baud_q;
         end else begin
            brgCnt_q <= brgCnt_q - 16'h0001;
         end
      end
   end
   assign tick = mode == 2'h0 ? 1'b1 :
                 stat_q[STAT_BAUDSEL] ? (timer1Ovf && !t1Tog_q) : brgCnt_q == 16'h0000;
   assign rxTick = tick;

   // holding buffer with ninth bit captured on write
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_q <= '0;
         holdFull_q <= 1'b0;
      end else begin
         if (dataWr && (stat_q[STAT_DBEN] || txSt_q == ST_IDLE) && !holdFull_q) begin
            hold_q.data <= {ctrl_q[CTRL_TXBIT8], wData_q[7:0]};
            holdFull_q <= 1'b1;
         end else if (txStartEv) begin
            holdFull_q <= 1'b0;
         end
      end
   end
   // frames start on a bit tick so the start bit gets a full bit period
   assign txStartEv = holdFull_q && txSt_q == ST_IDLE && tick;

   // transmitter
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         txSt_q <= ST_IDLE;
         txSh_q <= '0;
         txBit_q <= 4'h0;
         txPh_q <= 4'h0;
         txdOut <= 1'b1;
         rxdOut <= 1'b1;
      end else begin
         case (txSt_q)
            ST_IDLE: begin
               txdOut <= 1'b1;
               if (txStartEv) begin
                  txSh_q <= hold_q;
                  txBit_q <= 4'h0;
                  txPh_q <= 4'h0;
                  txSt_q <= mode == 2'h0 ? ST_BITS : ST_START;
               end
            end
            ST_START: begin
               txdOut <= 1'b0;
               if (tick) begin
                  txSt_q <= ST_BITS;
               end
            end
            ST_BITS: begin
               if (mode == 2'h0) begin
                  // data on receive pin, clock on transmit pin
                  txPh_q <= txPh_q + 4'h1;
                  txdOut <= txPh_q[3];
                  rxdOut <= txSh_q.data[txBit_q[2:0]];
                  if (txPh_q == MODE0_DIV) begin
                     txBit_q <= txBit_q + 4'h1;
                     if (txBit_q == 4'h7) begin
                        txSt_q <= ST_IDLE;
                     end
                  end
               end else begin
                  if (txBit_q == 4'h8 && !stat_q[STAT_DBEN]) begin
                     txdOut <= ctrl_q[CTRL_TXBIT8];
                  end else begin
                     txdOut <= txSh_q.data[txBit_q];
                  end
                  if (tick) begin
                     txBit_q <= txBit_q + 4'h1;
                     if (txBit_q == (mode == 2'h1 ? 4'h7 : 4'h8)) begin
                        txSt_q <= ST_STOP;
                     end
                  end
               end
            end
            ST_STOP: begin
               txdOut <= 1'b1;
               if (tick) begin
                  txSt_q <= ST_IDLE;
               end
            end
            default: txSt_q <= ST_IDLE;
         endcase
      end
   end
   assign txDone = (txSt_q == ST_STOP && tick) ||
                   (txSt_q == ST_BITS && mode == 2'h0 && txPh_q == MODE0_DIV && txBit_q == 4'h7);

   // receiver, sampling once per bit tick
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxSt_q <= ST_IDLE;
         rxSh_q <= 9'h000;
         rxBit_q <= 4'h0;
         rxBuf_q <= 8'h00;
         rxdOe_b <= 1'b1;
      end else begin
         rxdOe_b <= !(mode == 2'h0 && txSt_q == ST_BITS);
         case (rxSt_q)
            ST_IDLE: begin
               if (ctrl_q[CTRL_RXEN] && mode != 2'h0 && rxTick && !rxdIn) begin
                  rxSt_q <= ST_BITS;
                  rxBit_q <= 4'h0;
               end
            end
            ST_BITS: begin
               if (rxTick) begin
                  rxSh_q <= {rxdIn, rxSh_q[8:1]};
                  rxBit_q <= rxBit_q + 4'h1;
                  // nine samples: eight data bits, then stop bit or ninth bit
                  if (rxBit_q == 4'h8) begin
                     rxSt_q <= ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               rxBuf_q <= rxSh_q[7:0];
               rxSt_q <= ST_IDLE;
            end
            default: rxSt_q <= ST_IDLE;
         endcase
      end
   end
   assign rxDone = rxSt_q == ST_STOP;

   // sticky interrupts, write one to clear, set wins
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqSt_q <= 2'h0;
         irq <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wrGo && awAddr_q == ADDR_IRQ && wStrb_q[0] && wData_q[i]) begin
               irqSt_q[i] <= 1'b0;
            end
         end
         // tx event timing by buffering mode
         if (stat_q[STAT_DBEN] ? txStartEv : txDone) begin
            irqSt_q[IRQ_TX] <= 1'b1;
         end
         if (rxDone) begin
            irqSt_q[IRQ_RX] <= 1'b1;
         end
         irq <= |(irqSt_q & mask_q);
      end
   end
endmodule : uad_top

// ---- dv/uad_chk_sva.sv ----
`timescale 1ns/100ps
module uad_chk import uad_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic txdOut
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   chk_aw_pulse: assert property (awready |=> !awready)
      else $error("awready held");
   chk_ar_pulse: assert property (arready |=> !arready)
      else $error("arready held");
   chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("bvalid dropped");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("rvalid dropped");
   chk_b_follows: assert property (awvalid && awready |-> ##[1:4] bvalid)
      else $error("no write response");
   chk_rd_error: assert property (arvalid && arready && araddr > 8'h14
      |-> ##[1:3] rvalid && rresp == RESP_SLVERR)
      else $error("bad address not refused");
   chk_rd_okay: assert property (arvalid && arready && araddr <= 8'h14 && araddr[1:0] == 2'h0
      |-> ##[1:3] rvalid && rresp == RESP_OKAY)
      else $error("good address refused");
   chk_start_low: assert property ($fell(txdOut) |-> !txdOut [*7])
      else $error("short low bit");
   chk_txd_idle: assert property ($rose(rst_b) |-> txdOut)
      else $error("line not idle high");
   cover property (bvalid && bready);
   cover property (rvalid && rresp == RESP_SLVERR);
   cover property ($fell(txdOut));
endmodule : uad_chk
bind uad_top uad_chk u_chk (.core_clk, .rst_b, .awvalid, .awready, .bvalid, .bready, .bresp,
   .araddr, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .txdOut);

// ---- dv/uad_peer.sv ----
`timescale 1ns/100ps
module uad_peer (
   input wire logic core_clk,
   input wire logic txdOut,
   output logic peerRxd
);
   int bitLen = 17;
   int nBits = 10;
   int frames = 0;
   logic [10:0] frameQ;
   initial peerRxd = 1'b1;
   always begin
      @(negedge txdOut);
      frameQ = '0;
      repeat (bitLen / 2) @(posedge core_clk);
      for (int i = 0; i < nBits; i++) begin
         frameQ[i] = txdOut;
         if (i < nBits - 1) repeat (bitLen) @(posedge core_clk);
      end
      frames++;
   end
   // send low start, data, high stop
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         peerRxd <= f[i];
         repeat (bitLen) @(posedge core_clk);
      end
   endtask : send
endmodule : uad_peer

// ---- dv/test_uart_async_modes_double_buffer.sv ----
`timescale 1ns/100ps
module test_uart_async_modes_double_buffer import uad_pkg::*;;
   logic core_clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, rxdIn, rxdOut, rxdOe_b, txdOut, irq, peerRxd;
   logic [7:0] awaddr, araddr;
   logic t1Ovf = 1'b0;
   int t1Cnt = 0;
   logic [31:0] wdata, rdata, d, f1;
   logic [1:0] bresp, rresp, r;
   int errorCnt = 0;
   int nTests = 0;
   int cyc = 0;
   int f0;
   assign rxdIn = rxdOe_b ? peerRxd : rxdOut;
   uad_top DUT (.core_clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .rxdIn, .rxdOut, .rxdOe_b, .txdOut, .timer1Ovf(t1Ovf), .irq);
   uad_peer peer (.core_clk, .txdOut, .peerRxd);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // timer 1 overflow pulse, one every 17 cycles
   always @(posedge core_clk) begin
      t1Cnt <= t1Cnt == 16 ? 0 : t1Cnt + 1;
      t1Ovf <= t1Cnt == 16;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pa || pw) begin
         @(negedge core_clk);
         pa = pa && !awready;
         pw = pw && !wready;
         @(posedge core_clk);
         awvalid <= pa;
         wvalid <= pw;
      end
      do @(negedge core_clk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge core_clk);
      bready <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge core_clk); while (arready !== 1'b1);
      @(posedge core_clk);
      arvalid <= 1'b0;
      do @(negedge core_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      rready <= 1'b0;
      @(posedge core_clk);
   endtask : rd
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         errorCnt++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic txf(input logic [7:0] v, input int n);
      f0 = peer.frames;
      peer.nBits = n;
      wr(ADDR_DATA, {24'h0, v});
      wait (peer.frames == f0 + 1);
      idle(20);
   endtask : txf
   task automatic t_regs();
      rd(ADDR_CTRL);
      chk("ctrl", {24'h0, CTRL_RESET}, d);
      rd(ADDR_BAUD);
      chk("baud", {16'h0, BAUD_RESET}, d);
      rd(8'h18);
      chk("resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      rd(8'h02);
      chk("resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      wr(8'h18, 32'h0);
      chk("wresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      wr(ADDR_MASK, 32'h0);
      chk("wokay", {30'h0, RESP_OKAY}, {30'h0, r});
      $display("regs done");
   endtask : t_regs
   task automatic t_tx10();
      wr(ADDR_CTRL, 32'h50);
      txf(8'hA5, 10);
      chk("tx10", {21'h0, 11'h34A}, {21'h0, peer.frameQ});
      rd(ADDR_IRQ);
      chk("txirq", 32'h1, d & 32'h1);
      $display("tx10 done");
   endtask : t_tx10
   task automatic t_irq();
      idle(3);
      chk("irqmask", 32'h0, {31'h0, irq});
      wr(ADDR_MASK, 32'h1);
      idle(3);
      chk("irqon", 32'h1, {31'h0, irq});
      wr(ADDR_IRQ, 32'h3);
      idle(3);
      chk("irqclr", 32'h0, {31'h0, irq});
      $display("irq done");
   endtask : t_irq
   task automatic t_tx11();
      wr(ADDR_CTRL, 32'h98);
      f0 = peer.frames;
      peer.nBits = 11;
      wr(ADDR_DATA, 32'h3C);
      wr(ADDR_CTRL, 32'h90);
      wait (peer.frames == f0 + 1);
      idle(20);
      chk("tx11", {21'h0, 11'h478}, {21'h0, peer.frameQ});
      wr(ADDR_CTRL, 32'h98);
      txf(8'hC3, 11);
      chk("tx11b", {21'h0, 11'h786}, {21'h0, peer.frameQ});
      $display("tx11 done");
   endtask : t_tx11
   task automatic t_db();
      wr(ADDR_STAT, 32'h80);
      wr(ADDR_IRQ, 32'h3);
      f0 = peer.frames;
      wr(ADDR_DATA, 32'h11);
      idle(20);
      rd(ADDR_IRQ);
      chk("dbirq", 32'h1, d & 32'h1);
      wr(ADDR_IRQ, 32'h1);
      wr(ADDR_CTRL, 32'h90);
      wr(ADDR_DATA, 32'h22);
      wr(ADDR_CTRL, 32'h98);
      wait (peer.frames == f0 + 1);
      f1 = {21'h0, peer.frameQ};
      wait (peer.frames == f0 + 2);
      chk("db1", {21'h0, 11'h622}, f1);
      chk("db2", {21'h0, 11'h444}, {21'h0, peer.frameQ});
      idle(20);
      wr(ADDR_STAT, 32'h0);
      $display("db done");
   endtask : t_db
   task automatic t_rx();
      wr(ADDR_CTRL, 32'h50);
      peer.send({1'b0, 1'b1, 8'hC3, 1'b0}, 10);
      idle(20);
      rd(ADDR_DATA);
      chk("rx10", 32'hC3, d & 32'hFF);
      rd(ADDR_CTRL);
      chk("rxstop", 32'h1, {31'h0, d[CTRL_RXBIT8]});
      rd(ADDR_IRQ);
      chk("rxirq", 32'h2, d & 32'h2);
      wr(ADDR_CTRL, 32'h90);
      peer.send({1'b1, 1'b0, 8'h5A, 1'b0}, 11);
      idle(20);
      rd(ADDR_DATA);
      chk("rx11", 32'h5A, d & 32'hFF);
      rd(ADDR_CTRL);
      chk("rxbit9", 32'h0, {31'h0, d[CTRL_RXBIT8]});
      $display("rx done");
   endtask : t_rx
   task automatic t_baud();
      wr(ADDR_BAUD, 32'h13);
      peer.bitLen = 20;
      wr(ADDR_CTRL, 32'h50);
      txf(8'h96, 10);
      chk("baud20", {21'h0, 11'h32C}, {21'h0, peer.frameQ});
      $display("baud done");
   endtask : t_baud
   task automatic t_t1();
      wr(ADDR_STAT, 32'h40);
      peer.bitLen = 17;
      txf(8'h69, 10);
      chk("t1tx", {21'h0, 11'h2D2}, {21'h0, peer.frameQ});
      wr(ADDR_STAT, 32'h0);
      $display("timer1 done");
   endtask : t_t1
   task automatic t_m0();
      logic [7:0] got;
      logic oe;
      oe = 1'b0;
      got = 8'h00;
      wr(ADDR_CTRL, 32'h00);
      wr(ADDR_DATA, 32'hA5);
      for (int i = 0; i < 8; i++) begin
         @(posedge txdOut);
         got[i] = rxdOut;
         oe = oe | rxdOe_b;
      end
      chk("m0data", 32'hA5, {24'h0, got});
      chk("m0oe", 32'h0, {31'h0, oe});
      idle(20);
      $display("mode0 done");
   endtask : t_m0
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", nTests, errorCnt);
      if (errorCnt == 0 && nTests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errorCnt++;
         final_report();
      end
   end
   initial begin
      rst_b = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_tx10();
      t_irq();
      t_tx11();
      t_db();
      t_rx();
      t_baud();
      t_t1();
      t_m0();
      final_report();
   end
endmodule : test_uart_async_modes_double_buffer
